// *** src/bbps_defines.vh ***
// Constants for the buck-boost power-on supervisor: register offsets, field
// positions, reset values and timer figures. Included by the supervisor only.
`ifndef BBPS_DEFINES_VH
`define BBPS_DEFINES_VH

// Register offsets on the I2C map
`define BBPS_REG_STARTUP   8'h0e
`define BBPS_REG_DROPCOMP  8'h0f
`define BBPS_REG_OUTPUT_VOLTAGE_CODE_LO   8'h10
`define BBPS_REG_OUTPUT_VOLTAGE_CODE_HI   8'h11
`define BBPS_REG_POWER     8'h12
`define BBPS_REG_STATE     8'h20

// Field positions
`define BBPS_LL_EN_BIT     7
`define BBPS_LL_DLY_LSB    5
`define BBPS_WAIT_LSB      3
`define BBPS_SS_LSB        1
`define BBPS_COMP_LSB      0
`define BBPS_ILIM_LSB      2
`define BBPS_RAMP_LSB      3
`define BBPS_DN_SINK_BIT   5
`define BBPS_OV_SINK_BIT   6
`define BBPS_CC_BIT        3
`define BBPS_HIZ_BIT       4

// Reset values
`define BBPS_STARTUP_RST   8'h00
`define BBPS_DROPCOMP_RST  8'h04
`define BBPS_OUTPUT_VOLTAGE_CODE_RST      11'h1f4
`define BBPS_DVS_RST       4'h0
`define BBPS_I2C_ADDR      7'h2c
`define BBPS_FREQ_500K     2'h2

// Timebase: one tick per millisecond at a 4 ns clock
`define BBPS_TICK_CYCLES   18'h3d090
`define BBPS_OV_MS         15'h0064
`define BBPS_RETRY_MS      15'h0bb8
`define BBPS_LL_MS_10S     15'h2710
`define BBPS_LL_MS_20S     15'h4e20
`define BBPS_LL_MS_30S     15'h7530
`define BBPS_WAIT_MS_0     15'h0000
`define BBPS_WAIT_MS_1     15'h0064
`define BBPS_WAIT_MS_2     15'h01f4
`define BBPS_WAIT_MS_3     15'h03e8
`define BBPS_SS_MS_0       15'h0001
`define BBPS_SS_MS_1       15'h0002
`define BBPS_SS_MS_2       15'h0004
`define BBPS_SS_MS_3       15'h0008
`define BBPS_RAMP_CYC_0    11'h0fa
`define BBPS_RAMP_CYC_1    11'h1f4
`define BBPS_RAMP_CYC_2    11'h3e8
`define BBPS_RAMP_CYC_3    11'h7d0

`endif

// *** src/bbps_supervisor.v ***
// Power-on supervisor for a buck-boost converter with its I2C register slave.
// Assumes comparator and pin inputs are asynchronous; the analog loop acts on
// the enable and setting outputs.
`default_nettype none
`include "bbps_defines.vh"

// Summary of operation
// - Limit scale: 00 off, 10 double, else 1.5x
// - Overvoltage stops switching at once
// - Overvoltage over 100 ms enters high impedance
// - Drop compensation level from offset drop_compensation_config
// - Light-load off needs buck, headroom, below 6 V
// - Light-load enable bit at offset 0x0e
// - Low current must outlast 10/20/30 s delay
// - Light load latches off until power re-entry
// - Eleven-bit output code, writable while running
// - Reference ramps to new code at selected rate
// - Down-step sink on until regulation reached
// - Overvoltage sink while overvoltage, when enabled
// - State report at offset 0x20, live
// - State codes 000 to 100; 000 when off
// - Switching frequency fixed, 500 kHz default
// - Under 3 V: 3 s retry, then init
// - Current regulation flag in state report
// - Startup wait, then soft start, then regulate
module bbps_supervisor #(
  parameter [17:0] TICK_CYCLES         = `BBPS_TICK_CYCLES,
  parameter [6:0]  I2C_ADDR            = `BBPS_I2C_ADDR,
  parameter [1:0]  FACTORY_OPTION_CODE = `BBPS_FREQ_500K
) (
  // Clock and reset
  input  wire        sys_clk,
  input  wire        rstn,
  // Host pins
  input  wire        en_pin,
  input  wire        scl_in,
  input  wire        sda_in,
  output reg         sda_out_ff,
  output reg         sda_oe_ff,
  // Analog comparators
  input  wire        ov_cmp,
  input  wire        uv_cmp,
  input  wire        low_current,
  input  wire        buck_mode,
  input  wire        headroom_ok,
  input  wire        below_6v,
  input  wire        in_regulation,
  input  wire        cc_mode,
  // Converter controls
  output reg         switch_en_ff,
  output reg         output_en_ff,
  output reg         high_impedance_mode_ff,
  output reg         ilim_en_ff,
  output reg         ilim_double_ff,
  output reg  [1:0]  cord_comp_ff,
  output reg  [10:0] vref_ff,
  output reg         down_sink_ff,
  output reg         ov_sink_ff,
  output reg         soft_start_ff,
  output reg  [1:0]  freq_sel_ff
);

  localparam [2:0] ST_INIT = 3'b000;
  localparam [2:0] ST_SS   = 3'b001;
  localparam [2:0] ST_REG  = 3'b010;
  localparam [2:0] ST_RTRY = 3'b011;
  localparam [2:0] ST_LLOF = 3'b100;

  localparam [3:0] I_IDLE = 4'd0;
  localparam [3:0] I_ADDR = 4'd1;
  localparam [3:0] I_ACKA = 4'd2;
  localparam [3:0] I_PTR  = 4'd3;
  localparam [3:0] I_ACKP = 4'd4;
  localparam [3:0] I_WDAT = 4'd5;
  localparam [3:0] I_ACKW = 4'd6;
  localparam [3:0] I_RDAT = 4'd7;
  localparam [3:0] I_RACK = 4'd8;
  localparam [3:0] I_STRT = 4'd9;

  localparam       NIN    = 11;
  // Bus lines idle high; resetting their stages low would fake an edge
  localparam [NIN-1:0] SYNC_IDLE = 11'h600;

  // Input synchronisers: a change is taken once stages two and three agree
  wire [NIN-1:0] raw_in = {sda_in, scl_in, cc_mode, in_regulation, below_6v, headroom_ok,
                           buck_mode, low_current, uv_cmp, ov_cmp, en_pin};
  reg  [NIN-1:0] s1_ff;
  reg  [NIN-1:0] s2_ff;
  reg  [NIN-1:0] s3_ff;
  reg  [NIN-1:0] in_ff;
  genvar gi;
  generate
    for (gi = 0; gi < NIN; gi = gi + 1) begin : g_sync
      always @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
          s1_ff[gi] <= SYNC_IDLE[gi];
          s2_ff[gi] <= SYNC_IDLE[gi];
          s3_ff[gi] <= SYNC_IDLE[gi];
          in_ff[gi] <= SYNC_IDLE[gi];
        end else begin
          s1_ff[gi] <= raw_in[gi];
          s2_ff[gi] <= s1_ff[gi];
          s3_ff[gi] <= s2_ff[gi];
          if (s2_ff[gi] == s3_ff[gi]) begin
            in_ff[gi] <= s3_ff[gi];
          end
        end
      end
    end
  endgenerate
  wire en_s = in_ff[0];
  wire ov_s = in_ff[1];
  wire uv_s = in_ff[2];
  wire lo_s = in_ff[3];
  wire bk_s = in_ff[4];
  wire hr_s = in_ff[5];
  wire b6_s = in_ff[6];
  wire rg_s = in_ff[7];
  wire cc_s = in_ff[8];
  wire scl_s = in_ff[9];
  wire sda_s = in_ff[10];

  // Registers
  reg  [7:0]  startup_cfg_ff;
  reg  [7:0]  dropcomp_cfg_ff;
  reg  [10:0] output_voltage_code_code_ff;
  reg  [3:0]  dvs_cfg_ff;
  reg         pwr_req_ff;
  reg  [2:0]  state_ff;
  reg         wr_stb_ff;
  reg  [7:0]  wr_addr_ff;
  reg  [7:0]  wr_data_ff;

  wire power_mode = en_s & pwr_req_ff & ~high_impedance_mode_ff;

  function [7:0] rd_reg;
    input [7:0] a;
    begin
      case (a)
        `BBPS_REG_STARTUP:  rd_reg = startup_cfg_ff;
        `BBPS_REG_DROPCOMP: rd_reg = dropcomp_cfg_ff;
        `BBPS_REG_OUTPUT_VOLTAGE_CODE_LO:  rd_reg = output_voltage_code_code_ff[7:0];
        `BBPS_REG_OUTPUT_VOLTAGE_CODE_HI:  rd_reg = {1'b0, dvs_cfg_ff, output_voltage_code_code_ff[10:8]};
        `BBPS_REG_POWER:    rd_reg = {7'h00, pwr_req_ff};
        `BBPS_REG_STATE:    rd_reg = {3'h0, high_impedance_mode_ff, cc_s & power_mode,
                                      state_ff};
        default:            rd_reg = 8'h00;
      endcase
    end
  endfunction

  // I2C slave; the line is driven low only, so the output bit stays zero
  reg  [3:0] i2c_st_ff;
  reg  [2:0] bit_cnt_ff;
  reg  [7:0] shreg_ff;
  reg  [7:0] ptr_ff;
  reg        rw_ff;
  reg        mack_ff;
  reg        scl_d_ff;
  reg        sda_d_ff;
  wire       scl_rise = scl_s & ~scl_d_ff;
  wire       scl_fall = ~scl_s & scl_d_ff;
  wire       i2c_start = scl_s & scl_d_ff & sda_d_ff & ~sda_s;
  wire       i2c_stop  = scl_s & scl_d_ff & ~sda_d_ff & sda_s;
  wire [7:0] rd_now = rd_reg(ptr_ff);

  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      i2c_st_ff  <= I_IDLE;
      bit_cnt_ff <= 3'd7;
      shreg_ff   <= 8'h00;
      ptr_ff     <= 8'h00;
      rw_ff      <= 1'b0;
      mack_ff    <= 1'b0;
      scl_d_ff   <= 1'b1;
      sda_d_ff   <= 1'b1;
      sda_out_ff <= 1'b0;
      sda_oe_ff  <= 1'b0;
      wr_stb_ff  <= 1'b0;
      wr_addr_ff <= 8'h00;
      wr_data_ff <= 8'h00;
    end else begin
      scl_d_ff  <= scl_s;
      sda_d_ff  <= sda_s;
      wr_stb_ff <= 1'b0;
      if (i2c_start) begin
        i2c_st_ff  <= I_STRT;
        bit_cnt_ff <= 3'd7;
        sda_oe_ff  <= 1'b0;
      end else if (i2c_stop) begin
        i2c_st_ff <= I_IDLE;
        sda_oe_ff <= 1'b0;
      end else if (scl_rise) begin
        if (i2c_st_ff == I_ADDR || i2c_st_ff == I_PTR || i2c_st_ff == I_WDAT) begin
          shreg_ff <= {shreg_ff[6:0], sda_s};
        end
        if (i2c_st_ff == I_RACK) begin
          mack_ff <= ~sda_s;
        end
      end else if (scl_fall) begin
        case (i2c_st_ff)
          I_ADDR, I_PTR, I_WDAT: begin
            if (bit_cnt_ff != 3'd0) begin
              bit_cnt_ff <= bit_cnt_ff - 3'd1;
            end else if (i2c_st_ff == I_ADDR) begin
              if (shreg_ff[7:1] == I2C_ADDR) begin
                rw_ff     <= shreg_ff[0];
                sda_oe_ff <= 1'b1;
                i2c_st_ff <= I_ACKA;
              end else begin
                i2c_st_ff <= I_IDLE;
              end
            end else if (i2c_st_ff == I_PTR) begin
              ptr_ff    <= shreg_ff;
              sda_oe_ff <= 1'b1;
              i2c_st_ff <= I_ACKP;
            end else begin
              wr_stb_ff  <= 1'b1;
              wr_addr_ff <= ptr_ff;
              wr_data_ff <= shreg_ff;
              ptr_ff     <= ptr_ff + 8'h01;
              sda_oe_ff  <= 1'b1;
              i2c_st_ff  <= I_ACKW;
            end
          end
          I_ACKA, I_ACKP, I_ACKW: begin
            bit_cnt_ff <= 3'd7;
            if (i2c_st_ff == I_ACKA && rw_ff) begin
              shreg_ff  <= rd_now;
              sda_oe_ff <= ~rd_now[7];
              ptr_ff    <= ptr_ff + 8'h01;
              i2c_st_ff <= I_RDAT;
            end else begin
              sda_oe_ff <= 1'b0;
              i2c_st_ff <= (i2c_st_ff == I_ACKA) ? I_PTR : I_WDAT;
            end
          end
          I_RDAT: begin
            if (bit_cnt_ff == 3'd0) begin
              sda_oe_ff <= 1'b0;
              i2c_st_ff <= I_RACK;
            end else begin
              shreg_ff   <= {shreg_ff[6:0], 1'b0};
              sda_oe_ff  <= ~shreg_ff[6];
              bit_cnt_ff <= bit_cnt_ff - 3'd1;
            end
          end
          I_RACK: begin
            if (mack_ff) begin
              shreg_ff   <= rd_now;
              sda_oe_ff  <= ~rd_now[7];
              ptr_ff     <= ptr_ff + 8'h01;
              bit_cnt_ff <= 3'd7;
              i2c_st_ff  <= I_RDAT;
            end else begin
              i2c_st_ff <= I_IDLE;
            end
          end
          // The SCL fall that closes a START carries no bit
          I_STRT: i2c_st_ff <= I_ADDR;
          default: i2c_st_ff <= I_IDLE;
        endcase
      end
    end
  end

  // Register writes; a lower output code may request the down-step sink
  reg dn_req_ff;
  wire [10:0] nxt_output_voltage_code_code = (wr_addr_ff == `BBPS_REG_OUTPUT_VOLTAGE_CODE_LO) ?
                              {output_voltage_code_code_ff[10:8], wr_data_ff} :
                              {wr_data_ff[2:0], output_voltage_code_code_ff[7:0]};
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      startup_cfg_ff  <= `BBPS_STARTUP_RST;
      dropcomp_cfg_ff <= `BBPS_DROPCOMP_RST;
      output_voltage_code_code_ff    <= `BBPS_OUTPUT_VOLTAGE_CODE_RST;
      dvs_cfg_ff      <= `BBPS_DVS_RST;
      pwr_req_ff      <= 1'b1;
      dn_req_ff       <= 1'b0;
    end else begin
      dn_req_ff <= 1'b0;
      if (wr_stb_ff) begin
        case (wr_addr_ff)
          `BBPS_REG_STARTUP:  startup_cfg_ff  <= wr_data_ff;
          `BBPS_REG_DROPCOMP: dropcomp_cfg_ff <= wr_data_ff;
          `BBPS_REG_POWER:    pwr_req_ff      <= wr_data_ff[0];
          `BBPS_REG_OUTPUT_VOLTAGE_CODE_LO, `BBPS_REG_OUTPUT_VOLTAGE_CODE_HI: begin
            output_voltage_code_code_ff <= nxt_output_voltage_code_code;
            if (wr_addr_ff == `BBPS_REG_OUTPUT_VOLTAGE_CODE_HI) begin
              dvs_cfg_ff <= wr_data_ff[6:3];
            end
            dn_req_ff <= dvs_cfg_ff[`BBPS_DN_SINK_BIT - 3] & (nxt_output_voltage_code_code < output_voltage_code_code_ff);
          end
          default: ;
        endcase
      end
    end
  end

  reg  [17:0] tick_cnt_ff;
  reg         tick_ff;
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      tick_cnt_ff <= 18'h00000;
      tick_ff     <= 1'b0;
    end else begin
      tick_ff     <= (tick_cnt_ff == TICK_CYCLES - 18'h00001);
      tick_cnt_ff <= (tick_cnt_ff == TICK_CYCLES - 18'h00001) ? 18'h00000 :
                     tick_cnt_ff + 18'h00001;
    end
  end

  // Timer limits from configuration fields
  wire [1:0] ll_sel   = startup_cfg_ff[`BBPS_LL_DLY_LSB +: 2];
  wire [1:0] wait_sel = startup_cfg_ff[`BBPS_WAIT_LSB +: 2];
  wire [1:0] ss_sel   = startup_cfg_ff[`BBPS_SS_LSB +: 2];
  wire [1:0] ramp_sel = dvs_cfg_ff[1:0];
  reg  [14:0] ll_ms;
  reg  [14:0] wait_ms;
  reg  [14:0] ss_ms;
  reg  [10:0] ramp_cyc;
  always @* begin
    case (ll_sel)
      2'b00:   ll_ms = `BBPS_LL_MS_10S;
      2'b01:   ll_ms = `BBPS_LL_MS_20S;
      default: ll_ms = `BBPS_LL_MS_30S;
    endcase
    case (wait_sel)
      2'b00:   wait_ms = `BBPS_WAIT_MS_0;
      2'b01:   wait_ms = `BBPS_WAIT_MS_1;
      2'b10:   wait_ms = `BBPS_WAIT_MS_2;
      default: wait_ms = `BBPS_WAIT_MS_3;
    endcase
    case (ss_sel)
      2'b00:   ss_ms = `BBPS_SS_MS_0;
      2'b01:   ss_ms = `BBPS_SS_MS_1;
      2'b10:   ss_ms = `BBPS_SS_MS_2;
      default: ss_ms = `BBPS_SS_MS_3;
    endcase
    case (ramp_sel)
      2'b00:   ramp_cyc = `BBPS_RAMP_CYC_0;
      2'b01:   ramp_cyc = `BBPS_RAMP_CYC_1;
      2'b10:   ramp_cyc = `BBPS_RAMP_CYC_2;
      default: ramp_cyc = `BBPS_RAMP_CYC_3;
    endcase
  end

  wire ll_cond = startup_cfg_ff[`BBPS_LL_EN_BIT] & bk_s & hr_s & b6_s & lo_s &
                 (state_ff == ST_REG);
  reg  [14:0] st_ms_ff;
  reg  [14:0] ov_ms_ff;
  reg  [14:0] ll_ms_ff;

  // Power-on state machine
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      state_ff               <= ST_INIT;
      st_ms_ff               <= 15'h0000;
      ov_ms_ff               <= 15'h0000;
      ll_ms_ff               <= 15'h0000;
      high_impedance_mode_ff <= 1'b0;
    end else begin
      if (!ov_s || !power_mode) begin
        ov_ms_ff <= 15'h0000;
      end else if (tick_ff && ov_ms_ff <= `BBPS_OV_MS) begin
        ov_ms_ff <= ov_ms_ff + 15'h0001;
      end
      if (!ll_cond) begin
        ll_ms_ff <= 15'h0000;
      end else if (tick_ff && ll_ms_ff <= ll_ms) begin
        ll_ms_ff <= ll_ms_ff + 15'h0001;
      end
      // High impedance holds until the enable pin or the power request goes low
      if (!(en_s & pwr_req_ff)) begin
        high_impedance_mode_ff <= 1'b0;
      end else if (ov_ms_ff > `BBPS_OV_MS) begin
        high_impedance_mode_ff <= 1'b1;
      end
      if (!power_mode) begin
        state_ff <= ST_INIT;
        st_ms_ff <= 15'h0000;
      end else begin
        if (tick_ff) begin
          st_ms_ff <= st_ms_ff + 15'h0001;
        end
        case (state_ff)
          ST_INIT: begin
            if (st_ms_ff >= wait_ms && !ov_s) begin
              state_ff <= ST_SS;
              st_ms_ff <= 15'h0000;
            end
          end
          ST_SS: begin
            if (st_ms_ff >= ss_ms) begin
              state_ff <= ST_REG;
              st_ms_ff <= 15'h0000;
            end
          end
          ST_REG: begin
            st_ms_ff <= 15'h0000;
            if (uv_s) begin
              state_ff <= ST_RTRY;
            end else if (ll_ms_ff > ll_ms) begin
              state_ff <= ST_LLOF;
            end
          end
          ST_RTRY: begin
            if (st_ms_ff >= `BBPS_RETRY_MS) begin
              state_ff <= ST_INIT;
              st_ms_ff <= 15'h0000;
            end
          end
          ST_LLOF: begin
            st_ms_ff <= 15'h0000;
          end
          default: begin
            state_ff <= ST_INIT;
            st_ms_ff <= 15'h0000;
          end
        endcase
      end
    end
  end

  // Reference ramp, converter controls and sinks
  reg  [10:0] ramp_cnt_ff;
  wire        running = power_mode & (state_ff == ST_SS || state_ff == ST_REG);
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      ramp_cnt_ff    <= 11'h000;
      vref_ff        <= `BBPS_OUTPUT_VOLTAGE_CODE_RST;
      switch_en_ff   <= 1'b0;
      output_en_ff   <= 1'b0;
      soft_start_ff  <= 1'b0;
      ilim_en_ff     <= 1'b0;
      ilim_double_ff <= 1'b0;
      cord_comp_ff   <= 2'b00;
      down_sink_ff   <= 1'b0;
      ov_sink_ff     <= 1'b0;
      freq_sel_ff    <= `BBPS_FREQ_500K;
    end else begin
      freq_sel_ff <= FACTORY_OPTION_CODE;
      if (!running || vref_ff == output_voltage_code_code_ff) begin
        ramp_cnt_ff <= 11'h000;
        if (!running) begin
          vref_ff <= output_voltage_code_code_ff;
        end
      end else if (ramp_cnt_ff >= ramp_cyc - 11'h001) begin
        ramp_cnt_ff <= 11'h000;
        vref_ff     <= (vref_ff < output_voltage_code_code_ff) ? vref_ff + 11'h001 : vref_ff - 11'h001;
      end else begin
        ramp_cnt_ff <= ramp_cnt_ff + 11'h001;
      end
      switch_en_ff  <= running & ~ov_s;
      output_en_ff  <= running;
      soft_start_ff <= power_mode & (state_ff == ST_SS);
      ilim_en_ff     <= dropcomp_cfg_ff[`BBPS_ILIM_LSB +: 2] != 2'b00;
      ilim_double_ff <= dropcomp_cfg_ff[`BBPS_ILIM_LSB +: 2] == 2'b10;
      cord_comp_ff <= dropcomp_cfg_ff[`BBPS_COMP_LSB +: 2];
      // overvoltage sink
      // Kept on in high impedance mode while the overvoltage lasts
      ov_sink_ff <= dvs_cfg_ff[`BBPS_OV_SINK_BIT - 3] & ov_s;
      // release at regulation; a new request wins
      if (dn_req_ff && power_mode) begin
        down_sink_ff <= 1'b1;
      end else if (!power_mode || (rg_s && vref_ff == output_voltage_code_code_ff)) begin
        down_sink_ff <= 1'b0;
      end
    end
  end

endmodule // bbps_supervisor
`default_nettype wire

// *** test/bbps_supervisor_monitor.sv ***
// Checker bound to the power-on supervisor ports.
// Assumes one clock domain and an active-low asynchronous reset.
`default_nettype none
module bbps_monitor #(
  parameter [17:0] TICK_CYCLES         = 18'h0000a,
  parameter [1:0]  FACTORY_OPTION_CODE = 2'h2
) (
  // Clock, reset and pins
  input wire logic        sys_clk,
  input wire logic        rstn,
  input wire logic        en_pin,
  input wire logic        ov_cmp,
  // Converter controls
  input wire logic        switch_en_ff,
  input wire logic        output_en_ff,
  input wire logic        high_impedance_mode_ff,
  input wire logic        ilim_en_ff,
  input wire logic        ilim_double_ff,
  input wire logic [10:0] vref_ff,
  input wire logic        down_sink_ff,
  input wire logic        ov_sink_ff,
  input wire logic        soft_start_ff,
  input wire logic [1:0]  freq_sel_ff
);
  timeunit 1ns;
  timeprecision 1ps;
  int unsigned ov_run_ff;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  // Length of the present overvoltage episode, in clocks
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) ov_run_ff <= 0;
    else ov_run_ff <= ov_cmp ? ov_run_ff + 1 : 0;
  end
  // Six clocks leave room for the pin synchroniser
  sequence s_ov_held; ov_cmp [*6]; endsequence
  sequence s_ov_gone; !ov_cmp [*8]; endsequence
  sequence s_off_held; !en_pin [*8]; endsequence
  a_ov_stops_switch: assert property (s_ov_held |-> !switch_en_ff)
    else $error("switching during overvoltage");
  a_ov_sink_gone: assert property (s_ov_gone |-> !ov_sink_ff)
    else $error("overvoltage sink on without overvoltage");
  a_hiz_not_early: assert property (
    $rose(high_impedance_mode_ff) |-> ov_run_ff >= 99 * TICK_CYCLES)
    else $error("high impedance entered too early");
  a_hiz_output_off: assert property (high_impedance_mode_ff [*3] |-> !output_en_ff)
    else $error("output on in high impedance mode");
  a_ilim_double_on: assert property (ilim_double_ff |-> ilim_en_ff)
    else $error("double limit with limiting off");
  a_soft_output_on: assert property (soft_start_ff |-> output_en_ff)
    else $error("soft start without output");
  a_power_off_idle: assert property (
    s_off_held |-> !output_en_ff && !soft_start_ff && !down_sink_ff)
    else $error("activity after leaving power mode");
  a_vref_ramp_step: assert property (
    output_en_ff && $past(output_en_ff) && $past(output_en_ff, 2)
    |-> (vref_ff - $past(vref_ff) + 11'h001) <= 11'h002)
    else $error("reference jumped instead of ramping");
  a_freq_fixed: assert property (freq_sel_ff == FACTORY_OPTION_CODE)
    else $error("frequency option changed");
endmodule // bbps_monitor
`default_nettype wire

// *** test/bbps_host.sv ***
// Host model: I2C controller and enable pin driver.
// Assumes the bench resolves the pulled-up SDA wire; SCL idles high.
`default_nettype none
module bbps_host #(
  parameter int       H    = 20,
  parameter bit [6:0] ADDR = 7'h2c
) (
  // Clock
  input  wire logic sys_clk,
  // Pins toward the supervisor
  input  wire logic sda_wire,
  output var  logic scl,
  output var  logic sda_low,
  output var  logic en_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
    en_pin = 1'b0;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic start();
    @(posedge sys_clk);
    sda_low <= 1'b1;
    wt(H);
    scl <= 1'b0;
    wt(H / 2);
  endtask
  task automatic stop();
    sda_low <= 1'b1;
    wt(H);
    scl <= 1'b1;
    wt(H);
    sda_low <= 1'b0;
    wt(H);
  endtask
  // Data moves mid low phase so the synchroniser never sees a false START
  task automatic bitx(input logic b, output logic r);
    sda_low <= !b;
    wt(H);
    scl <= 1'b1;
    wt(H);
    r = sda_wire;
    scl <= 1'b0;
    wt(H / 2);
  endtask
  task automatic xfer(input logic [7:0] d, output logic [7:0] q, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bitx(d[i], q[i]);
    bitx(1'b1, r);
    ack = !r;
  endtask
  // settings and output code written at any time
  task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic ok);
    logic [7:0] q;
    logic k0, k1, k2;
    start();
    xfer({ADDR, 1'b0}, q, k0);
    xfer(a, q, k1);
    xfer(d, q, k2);
    stop();
    ok = k0 & k1 & k2;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    logic [7:0] q;
    logic k;
    start();
    xfer({ADDR, 1'b0}, q, k);
    xfer(a, q, k);
    stop();
    start();
    xfer({ADDR, 1'b1}, q, k);
    xfer(8'hff, d, k);
    stop();
  endtask
  // leave and re-enter power mode through the pin
  task automatic toggle_en();
    @(posedge sys_clk);
    en_pin <= 1'b0;
    wt(20);
    en_pin <= 1'b1;
  endtask
endmodule // bbps_host
`default_nettype wire

// *** test/bbps_supervisor_test.sv ***
// Self-checking bench for the power-on supervisor with a host model.
// Assumes a shortened timebase: one millisecond is TICK clocks.
`default_nettype none
module bbps_supervisor_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam bit [17:0] TICK = 18'h00002;
  logic sys_clk, rstn, ov_cmp, uv_cmp, low_current, buck_mode;
  logic headroom_ok, below_6v, in_regulation, cc_mode;
  wire logic scl, sda_low, en_pin, sda_in, sda_out_ff, sda_oe_ff, switch_en_ff;
  wire logic output_en_ff, high_impedance_mode_ff, ilim_en_ff, ilim_double_ff;
  wire logic down_sink_ff, ov_sink_ff, soft_start_ff;
  wire logic [1:0]  cord_comp_ff, freq_sel_ff;
  wire logic [10:0] vref_ff;
  int num_errors = 0;
  int n_checks = 0;
  // Pulled-up SDA: low while either party pulls it
  assign sda_in = !(sda_low | sda_oe_ff);
  bbps_supervisor #(.TICK_CYCLES(TICK)) bbps_supervisor_i (
    .sys_clk(sys_clk), .rstn(rstn), .en_pin(en_pin), .scl_in(scl), .sda_in(sda_in),
    .sda_out_ff(sda_out_ff), .sda_oe_ff(sda_oe_ff), .ov_cmp(ov_cmp), .uv_cmp(uv_cmp),
    .low_current(low_current), .buck_mode(buck_mode), .headroom_ok(headroom_ok),
    .below_6v(below_6v), .in_regulation(in_regulation), .cc_mode(cc_mode),
    .switch_en_ff(switch_en_ff), .output_en_ff(output_en_ff),
    .high_impedance_mode_ff(high_impedance_mode_ff), .ilim_en_ff(ilim_en_ff),
    .ilim_double_ff(ilim_double_ff), .cord_comp_ff(cord_comp_ff), .vref_ff(vref_ff),
    .down_sink_ff(down_sink_ff), .ov_sink_ff(ov_sink_ff),
    .soft_start_ff(soft_start_ff), .freq_sel_ff(freq_sel_ff)
  );
  bbps_host bbps_host_i (
    .sys_clk(sys_clk), .sda_wire(sda_in), .scl(scl), .sda_low(sda_low), .en_pin(en_pin)
  );
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    n_checks++;
    if (g !== e) begin
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
      num_errors++;
    end
  endtask
  task automatic ws(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    bbps_host_i.rd(a, d);
    chk({8'h00, d}, {8'h00, e});
  endtask
  task automatic wc(input logic [7:0] a, input logic [7:0] d);
    logic ok;
    bbps_host_i.wr(a, d, ok);
    chk(16'(ok), 16'h0001);
  endtask
  task automatic wait_oe(input logic v, input int lim);
    for (int k = 0; k < lim && output_en_ff !== v; k++) ws(1);
    chk(16'(output_en_ff), 16'(v));
    if (output_en_ff !== v) report_and_stop();
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    rstn = 1'b0;
    in_regulation = 1'b1;
    {ov_cmp, uv_cmp, low_current, buck_mode, headroom_ok, below_6v, cc_mode} = '0;
    ws(12);
    @(posedge sys_clk) rstn <= 1'b1;
    ws(8);
    rc(8'h0e, 8'h00);
    rc(8'h0f, 8'h04);
    rc(8'h10, 8'hf4);
    wc(8'h20, 8'hff);
    rc(8'h20, 8'h00);
    rc(8'h30, 8'h00);
    chk(16'(freq_sel_ff), 16'h0002);
    chk(16'(sda_out_ff), 16'h0000);
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      wc(8'h0f, 8'(i * 5));
      ws(2);
      chk(16'(ilim_en_ff), 16'(i != 0));
      chk(16'(ilim_double_ff), 16'(i == 2));
      chk(16'(cord_comp_ff), 16'(i));
    end
    $display("test limits done");
    bbps_host_i.toggle_en();
    wait_oe(1'b1, 400);
    chk(16'(soft_start_ff), 16'h0001);
    ws(40);
    chk(16'(soft_start_ff), 16'h0000);
    chk(16'(switch_en_ff), 16'h0001);
    rc(8'h20, 8'h02);
    @(posedge sys_clk) cc_mode <= 1'b1;
    rc(8'h20, 8'h0a);
    @(posedge sys_clk) cc_mode <= 1'b0;
    $display("test startup done");
    wc(8'h11, 8'h61);
    @(posedge sys_clk) in_regulation <= 1'b0;
    wc(8'h10, 8'hf0);
    ws(2);
    chk(16'(down_sink_ff), 16'h0001);
    chk(16'(vref_ff > 11'h1f2), 16'h0001);
    ws(1300);
    chk(16'(vref_ff), 16'h01f0);
    chk(16'(down_sink_ff), 16'h0001);
    @(posedge sys_clk) in_regulation <= 1'b1;
    ws(10);
    chk(16'(down_sink_ff), 16'h0000);
    $display("test output code done");
    @(posedge sys_clk) ov_cmp <= 1'b1;
    ws(8);
    chk(16'(switch_en_ff), 16'h0000);
    chk(16'(ov_sink_ff), 16'h0001);
    ws(170);
    chk(16'(high_impedance_mode_ff), 16'h0000);
    ws(60);
    chk(16'(high_impedance_mode_ff), 16'h0001);
    @(posedge sys_clk) ov_cmp <= 1'b0;
    rc(8'h20, 8'h10);
    bbps_host_i.toggle_en();
    wait_oe(1'b1, 400);
    chk(16'(high_impedance_mode_ff), 16'h0000);
    $display("test overvoltage done");
    @(posedge sys_clk) uv_cmp <= 1'b1;
    ws(10);
    chk(16'(output_en_ff), 16'h0000);
    @(posedge sys_clk) uv_cmp <= 1'b0;
    rc(8'h20, 8'h03);
    ws(2700);
    chk(16'(output_en_ff), 16'h0000);
    wait_oe(1'b1, 4000);
    $display("test undervoltage done");
    @(posedge sys_clk) {buck_mode, headroom_ok, below_6v, low_current} <= 4'hf;
    ws(12000);
    chk(16'(output_en_ff), 16'h0001);
    wc(8'h0e, 8'h80);
    ws(19000);
    chk(16'(output_en_ff), 16'h0001);
    wait_oe(1'b0, 3000);
    rc(8'h20, 8'h04);
    @(posedge sys_clk) low_current <= 1'b0;
    ws(100);
    chk(16'(output_en_ff), 16'h0000);
    bbps_host_i.toggle_en();
    wait_oe(1'b1, 400);
    $display("test light load done");
    wc(8'h12, 8'h00);
    wait_oe(1'b0, 100);
    rc(8'h20, 8'h00);
    wc(8'h12, 8'h01);
    wait_oe(1'b1, 400);
    $display("test power request done");
    report_and_stop();
  end
endmodule // bbps_supervisor_test
bind bbps_supervisor bbps_monitor #(
  .TICK_CYCLES(TICK_CYCLES), .FACTORY_OPTION_CODE(FACTORY_OPTION_CODE)
) bbps_monitor_i (
  .sys_clk(sys_clk), .rstn(rstn), .en_pin(en_pin), .ov_cmp(ov_cmp),
  .switch_en_ff(switch_en_ff), .output_en_ff(output_en_ff), .vref_ff(vref_ff),
  .high_impedance_mode_ff(high_impedance_mode_ff), .ilim_en_ff(ilim_en_ff),
  .ilim_double_ff(ilim_double_ff), .down_sink_ff(down_sink_ff),
  .ov_sink_ff(ov_sink_ff), .soft_start_ff(soft_start_ff), .freq_sel_ff(freq_sel_ff)
);
`default_nettype wire
